// *** bench/irq_vectoring_assertions.sv ***
// Concurrent checks on the ports of the interrupt vectoring logic
module irq_vectoring_checker (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [7:0]               paddr,
    input wire logic [31:0]              pwdata,
    input wire logic                     pready,
    input wire logic [31:0]              prdata,
    input wire logic                     pslverr,
    input wire irq_vec_pkg::cpu_status_t cpu,
    input wire irq_vec_pkg::vector_call_t call,
    input wire logic                     cpu_halted,
    input wire logic                     periph_halted
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_wait_s;
        psel && penable && !pready;
    endsequence
    sequence ctrl_pdown_s;
        psel && penable && pready && pwrite && paddr == irq_vec_pkg::OFS_CTRL && pwdata[4];
    endsequence
    sequence run_call_s;
        call.valid && !$past(cpu_halted);
    endsequence

    apb_wait_a: assert property (apb_wait_s |=> pready ##1 !pready)
        else $error("APB access not answered in one wait cycle");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response without ready or with data");
    call_gate_a: assert property (run_call_s |-> $past(cpu.last_cycle)
        && !$past(cpu.writes_irq_regs) && !$past(cpu.return_from_interrupt))
        else $error("call taken outside an allowed cycle");
    vector_map_a: assert property (call.valid |-> call.vector ==
        irq_vec_pkg::VEC_BASE + irq_vec_pkg::VEC_STEP * 16'(call.source))
        else $error("vector does not match source");
    push_pc_a: assert property (run_call_s |-> call.push_pc == $past(cpu.next_pc))
        else $error("pushed address is not the following instruction");
    wake_call_a: assert property ($fell(cpu_halted) |-> call.valid)
        else $error("wake without a service call");
    pd_both_a: assert property (periph_halted |-> cpu_halted)
        else $error("peripherals halted while cpu runs");
    pd_entry_a: assert property (ctrl_pdown_s |-> ##[1:2] (periph_halted && cpu_halted))
        else $error("power-down not entered");
endmodule

bind irq_vectoring irq_vectoring_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cpu(cpu), .call(call), .cpu_halted(cpu_halted),
    .periph_halted(periph_halted));

// *** bench/irq_vectoring_tb_top.sv ***
// Self-checking bench for the interrupt vectoring logic
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module irq_vectoring_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic                       ext0_pin_n, ext1_pin_n, cpu_halted, periph_halted, irq, q_err;
    logic [7:0]                 paddr;
    logic [31:0]                pwdata, prdata, q;
    irq_vec_pkg::cpu_status_t   cpu;
    irq_vec_pkg::src_events_t   ev;
    irq_vec_pkg::vector_call_t  call;
    int                         errors, n_tests;
    int                         srcs[4] = '{1, 3, 6, 7};
    int                         bits[4] = '{5, 4, 3, 2};

    irq_vectoring u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cpu(cpu), .events(ev), .ext0_pin_n(ext0_pin_n),
        .ext1_pin_n(ext1_pin_n), .call(call), .cpu_halted(cpu_halted),
        .periph_halted(periph_halted), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic give_up(input string what);
        errors++;
        $display("CHECK FAILED %s expected 1 seen 0", what);
        complete_run;
    endtask

    // Ready and read data are taken at the rising edge; the request stands until then
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) give_up("pready");
        q = prdata;
        q_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("register read", e, q & m)
    endtask

    task automatic expect_call(input logic [2:0] s);
        int k;
        k = 0;
        do begin @(negedge pclk); k++; end while (call.valid !== 1'b1 && k < 30);
        if (k >= 30) give_up("call.valid");
        `CHK("call source", s, call.source)
        `CHK("call vector", irq_vec_pkg::VEC_BASE + irq_vec_pkg::VEC_STEP * 16'(s), call.vector)
        `CHK("call push_pc", 16'h1234, call.push_pc)
        @(posedge pclk);
    endtask

    task automatic no_call(input int n);
        repeat (n) begin
            @(negedge pclk);
            `CHK("no call", 1'b0, call.valid)
        end
        @(posedge pclk);
    endtask

    task automatic pins_are(input logic c, input logic p);
        repeat (2) @(negedge pclk);
        `CHK("cpu_halted", c, cpu_halted)
        `CHK("periph_halted", p, periph_halted)
        @(posedge pclk);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(negedge pclk);
        `CHK("irq", e, irq)
        @(posedge pclk);
    endtask

    task automatic ret;
        cpu.return_from_interrupt <= 1'b1;
        @(posedge pclk);
        cpu.return_from_interrupt <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    initial begin : main
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0000_0000; cpu = '0; ev = '0; ext0_pin_n = 1'b1; ext1_pin_n = 1'b1;
        errors = 0; n_tests = 0; q_err = 1'b0;
        cpu.next_pc = 16'h1234;
        cyc(5);
        presetn <= 1'b1;
        rd(irq_vec_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(irq_vec_pkg::OFS_ENABLE, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        `CHK("unmapped slverr", 1'b1, q_err)
        `CHK("unmapped data", 32'h0000_0000, q)
        $display("test reset done");
        wr(irq_vec_pkg::OFS_ENABLE, 32'h0000_00FF);
        wr(irq_vec_pkg::OFS_CTRL, 32'h0000_0004);
        // Timers lose their flag on the call, transfer-complete and watchdog keep it
        for (int i = 0; i < 4; i++) begin
            ev[bits[i]] <= 1'b1;
            @(posedge pclk);
            ev[5:2] <= 4'h0;
            rd(irq_vec_pkg::OFS_FLAGS, 32'h1 << srcs[i], 32'h1 << srcs[i]);
            cpu.last_cycle <= 1'b1;
            expect_call(3'(srcs[i]));
            cpu.last_cycle <= 1'b0;
            rd(irq_vec_pkg::OFS_FLAGS, 32'h1 << srcs[i], i < 2 ? 32'h0 : 32'h1 << srcs[i]);
            wr(irq_vec_pkg::OFS_FLAGS, 32'h0000_00FF);
            ret;
        end
        $display("test sources done");
        ev.serial_flag <= 1'b1; cpu.writes_irq_regs <= 1'b1; cpu.last_cycle <= 1'b1;
        no_call(4);
        cpu.writes_irq_regs <= 1'b0;
        expect_call(3'd4);
        cpu.last_cycle <= 1'b0;
        rd(irq_vec_pkg::OFS_FLAGS, 32'h0000_0010, 32'h0000_0010);
        ev.serial_flag <= 1'b0;
        ret;
        ev.timer2_flag <= 1'b1;
        cyc(2);
        ev.timer2_flag <= 1'b0;
        cyc(2);
        cpu.last_cycle <= 1'b1;
        no_call(4);
        cpu.last_cycle <= 1'b0;
        $display("test withhold done");
        ev[5:4] <= 2'b11;
        @(posedge pclk);
        ev[5:4] <= 2'b00;
        cpu.last_cycle <= 1'b1;
        expect_call(3'd1);
        no_call(3);
        wr(irq_vec_pkg::OFS_PRIORITY, 32'h0000_0008);
        expect_call(3'd3);
        cpu.last_cycle <= 1'b0;
        ret;
        ret;
        wr(irq_vec_pkg::OFS_PRIORITY, 32'h0000_0000);
        $display("test priority done");
        ext0_pin_n <= 1'b0;
        cyc(2);
        rd(irq_vec_pkg::OFS_FLAGS, 32'h0000_0001, 32'h0000_0001);
        ext0_pin_n <= 1'b1;
        cyc(2);
        rd(irq_vec_pkg::OFS_FLAGS, 32'h0000_0001, 32'h0000_0000);
        wr(irq_vec_pkg::OFS_CTRL, 32'h0000_0005);
        ext0_pin_n <= 1'b0;
        @(posedge pclk);
        ext0_pin_n <= 1'b1;
        cyc(3);
        rd(irq_vec_pkg::OFS_FLAGS, 32'h0000_0001, 32'h0000_0001);
        cpu.last_cycle <= 1'b1;
        expect_call(3'd0);
        cpu.last_cycle <= 1'b0;
        rd(irq_vec_pkg::OFS_FLAGS, 32'h0000_0001, 32'h0000_0000);
        ret;
        wr(irq_vec_pkg::OFS_CTRL, 32'h0000_0004);
        ext0_pin_n <= 1'b0;
        cyc(2);
        cpu.last_cycle <= 1'b1;
        expect_call(3'd0);
        cpu.last_cycle <= 1'b0;
        rd(irq_vec_pkg::OFS_FLAGS, 32'h0000_0001, 32'h0000_0001);
        ext0_pin_n <= 1'b1;
        ret;
        $display("test external done");
        wr(irq_vec_pkg::OFS_EVT_MASK, 32'h0000_0001);
        irq_is(1'b1);
        wr(irq_vec_pkg::OFS_EVT_MASK, 32'h0000_0000);
        irq_is(1'b0);
        wr(irq_vec_pkg::OFS_EVT_MASK, 32'h0000_0001);
        wr(irq_vec_pkg::OFS_EVT_STAT, 32'h0000_0007);
        irq_is(1'b0);
        $display("test irq done");
        // Both sleep bits at once: power-down must win and stay away from idle on wake
        wr(irq_vec_pkg::OFS_CTRL, 32'h0000_001C);
        pins_are(1'b1, 1'b1);
        ev.wdog_timeout <= 1'b1;
        @(posedge pclk);
        ev.wdog_timeout <= 1'b0;
        expect_call(3'd7);
        pins_are(1'b0, 1'b0);
        rd(irq_vec_pkg::OFS_CTRL, 32'h0000_0018, 32'h0000_0000);
        ret;
        // Watchdog flag is left set by its call; clear it so only the timer wakes idle
        wr(irq_vec_pkg::OFS_FLAGS, 32'h0000_0080);
        wr(irq_vec_pkg::OFS_CTRL, 32'h0000_000C);
        pins_are(1'b1, 1'b0);
        ev.t0_overflow <= 1'b1;
        @(posedge pclk);
        ev.t0_overflow <= 1'b0;
        expect_call(3'd1);
        pins_are(1'b0, 1'b0);
        rd(irq_vec_pkg::OFS_CTRL, 32'h0000_0018, 32'h0000_0000);
        ret;
        $display("test sleep done");
        complete_run;
    end
endmodule

// *** rtl/irq_vec_pkg.sv ***
// Constants, types and register layout of the interrupt vectoring logic
// Contract
// - Take a vector call only if no equal or higher priority service is active.
// - Call only in the last machine cycle of the executing instruction.
// - Withhold the call while the instruction writes enable/priority registers or is a return.
// - Poll the request flags anew in every machine cycle.
// - A refused request that has gone away is never serviced; no pending memory.
// - Vectoring to a timer 0 or timer 1 routine clears that overflow flag.
// - Vectoring to an external pin routine clears its flag only in edge mode.
// - The call pushes the program counter only, then loads the source vector.
// - Type-select 0 means low-level trigger, 1 means falling-edge trigger.
// - External request flag is set on the edge or level chosen by type-select.
// - In edge mode the flag holds until software clears it or its routine is entered.
// - In level mode the flag is always the inverse of the pin level.
// - Transfer-complete flag requests service; runs only with own and global enable.
// - Wake-up clears the mode bit, runs the waking routine, resumes after the sleep.
// - Idle and power-down set together enter power-down, never idle after waking.
// - Watchdog time-out requests service when its enable and the global enable are set.
package irq_vec_pkg;

    localparam int NSRC = 8;

    // Source numbers, also the polling order: lower number wins
    localparam int SRC_EXT0   = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_EXT1   = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_SERIAL = 4;
    localparam int SRC_TIMER2 = 5;
    localparam int SRC_SPI    = 6;
    localparam int SRC_WDOG   = 7;

    // Vector address = base + source * step
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_ENABLE   = 8'h04;
    localparam logic [7:0] OFS_PRIORITY = 8'h08;
    localparam logic [7:0] OFS_FLAGS    = 8'h0C;
    localparam logic [7:0] OFS_EVT_STAT = 8'h10;
    localparam logic [7:0] OFS_EVT_MASK = 8'h14;
    localparam logic [7:0] OFS_STATE    = 8'h18;

    // Control register fields
    localparam int CTRL_EXT0_TYPE = 0;
    localparam int CTRL_EXT1_TYPE = 1;
    localparam int CTRL_GIE       = 2;
    localparam int CTRL_IDLE      = 3;
    localparam int CTRL_PDOWN     = 4;
    localparam int CTRL_W         = 5;

    // Event status fields
    localparam int EVT_CALL     = 0;
    localparam int EVT_WAKE     = 1;
    localparam int EVT_WITHHELD = 2;
    localparam int EVT_W        = 3;

    // Flags that software may clear by writing one
    localparam logic [7:0] FLAGS_SW_CLEAR = 8'hCF;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [7:0]        ENA_RST  = 8'h00;
    localparam logic [7:0]        PRI_RST  = 8'h00;
    localparam logic [EVT_W-1:0]  EVT_RST  = 3'h0;

    typedef enum {MODE_RUN, MODE_IDLE, MODE_PDOWN} power_mode_t;

    typedef struct packed {
        logic        last_cycle;
        logic        writes_irq_regs;
        logic        return_from_interrupt;
        logic [15:0] next_pc;
    } cpu_status_t;

    typedef struct packed {
        logic t0_overflow;
        logic t1_overflow;
        logic spi_done;
        logic wdog_timeout;
        logic serial_flag;
        logic timer2_flag;
    } src_events_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  source;
        logic [15:0] vector;
        logic [15:0] push_pc;
    } vector_call_t;

endpackage

// *** rtl/irq_vectoring.sv ***
// Interrupt vectoring logic with APB register access
module irq_vectoring (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire irq_vec_pkg::cpu_status_t    cpu,
    input  wire irq_vec_pkg::src_events_t    events,
    input  wire logic                        ext0_pin_n,
    input  wire logic                        ext1_pin_n,
    output irq_vec_pkg::vector_call_t        call,
    output logic                             cpu_halted,
    output logic                             periph_halted,
    output logic                             irq
);

    // Register state
    logic [irq_vec_pkg::CTRL_W-1:0] ctrl;
    logic [irq_vec_pkg::CTRL_W-1:0] next_ctrl;
    logic [7:0]                     enable;
    logic [7:0]                     next_enable;
    logic [7:0]                     priority_hi;
    logic [7:0]                     next_priority_hi;
    logic [irq_vec_pkg::EVT_W-1:0]  evt_status;
    logic [irq_vec_pkg::EVT_W-1:0]  next_evt_status;
    logic [irq_vec_pkg::EVT_W-1:0]  evt_mask;
    logic [irq_vec_pkg::EVT_W-1:0]  next_evt_mask;
    logic                           next_irq;

    // Request flags and pin history
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic       ext0_prev;
    logic       ext1_prev;

    // Service and power state
    logic [1:0]                 in_service;
    logic [1:0]                 next_in_service;
    irq_vec_pkg::power_mode_t   mode;
    irq_vec_pkg::power_mode_t   next_mode;
    irq_vec_pkg::vector_call_t  next_call;
    logic                       next_cpu_halted;
    logic                       next_periph_halted;

    // Bus
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        wr_en;
    logic        mapped;

    // Poll
    logic [7:0] pending;
    logic [7:0] pending_hi;
    logic [7:0] wake_src;
    logic       any_req;
    logic       sel_hi;
    logic [2:0] sel_src;
    logic       level_ok;
    logic       take_normal;
    logic       take_wake;
    logic       take;
    logic       withheld;
    logic [7:0] sw_clear;
    logic [7:0] call_clear;

    function automatic logic [2:0] first_index(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = irq_vec_pkg::NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // APB access: pready rises one cycle into the access phase
    assign wr_en = psel & penable & pready & pwrite;

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            irq_vec_pkg::OFS_CTRL,
            irq_vec_pkg::OFS_ENABLE,
            irq_vec_pkg::OFS_PRIORITY,
            irq_vec_pkg::OFS_FLAGS,
            irq_vec_pkg::OFS_EVT_STAT,
            irq_vec_pkg::OFS_EVT_MASK,
            irq_vec_pkg::OFS_STATE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_pready  = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~mapped;
        next_prdata  = 32'h0000_0000;
        if (psel & penable & ~pready & ~pwrite) begin
            case (paddr)
                irq_vec_pkg::OFS_CTRL:     next_prdata = {27'h000_0000, ctrl};
                irq_vec_pkg::OFS_ENABLE:   next_prdata = {24'h00_0000, enable};
                irq_vec_pkg::OFS_PRIORITY: next_prdata = {24'h00_0000, priority_hi};
                irq_vec_pkg::OFS_FLAGS:    next_prdata = {24'h00_0000, flags};
                irq_vec_pkg::OFS_EVT_STAT: next_prdata = {29'h0000_0000, evt_status};
                irq_vec_pkg::OFS_EVT_MASK: next_prdata = {29'h0000_0000, evt_mask};
                irq_vec_pkg::OFS_STATE: begin
                    next_prdata = {16'h0000, call.vector[7:0], 1'b0, call.source,
                                   cpu_halted, periph_halted, in_service};
                end
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Poll: every cycle starts fresh from the current flags, nothing is held over
    always_comb begin
        pending    = flags & enable & {8{ctrl[irq_vec_pkg::CTRL_GIE]}};
        pending_hi = pending & priority_hi;
        any_req    = |pending;
        sel_hi     = |pending_hi;
        sel_src    = sel_hi ? first_index(pending_hi) : first_index(pending);
        // High level in service blocks all; low level blocks only low requests
        level_ok   = ~in_service[1] & (~in_service[0] | sel_hi);
        // Peripheral clocks stop in power-down, so only pins and watchdog wake it
        wake_src   = (mode == irq_vec_pkg::MODE_PDOWN) ?
                     (pending & 8'h85) : pending;
        take_normal = (mode == irq_vec_pkg::MODE_RUN) & any_req & level_ok
                    & cpu.last_cycle
                    & ~cpu.writes_irq_regs & ~cpu.return_from_interrupt;
        // The core is parked between instructions while asleep
        take_wake  = (mode != irq_vec_pkg::MODE_RUN) & (|wake_src) & level_ok;
        take       = take_normal | take_wake;
        withheld   = (mode == irq_vec_pkg::MODE_RUN) & any_req & level_ok & cpu.last_cycle
                   & (cpu.writes_irq_regs | cpu.return_from_interrupt);
    end

    // Request flags
    always_comb begin
        sw_clear = 8'h00;
        if (wr_en && paddr == irq_vec_pkg::OFS_FLAGS) begin
            sw_clear = pwdata[7:0] & irq_vec_pkg::FLAGS_SW_CLEAR;
        end
        call_clear = 8'h00;
        if (take) begin
            case (sel_src)
                3'(irq_vec_pkg::SRC_TIMER0): call_clear[irq_vec_pkg::SRC_TIMER0] = 1'b1;
                3'(irq_vec_pkg::SRC_TIMER1): call_clear[irq_vec_pkg::SRC_TIMER1] = 1'b1;
                3'(irq_vec_pkg::SRC_EXT0):   call_clear[irq_vec_pkg::SRC_EXT0] = 1'b1;
                3'(irq_vec_pkg::SRC_EXT1):   call_clear[irq_vec_pkg::SRC_EXT1] = 1'b1;
                default:                     call_clear = 8'h00;
            endcase
        end
        next_flags = flags;
        // External 0: 1 selects falling edge, 0 selects low level
        if (ctrl[irq_vec_pkg::CTRL_EXT0_TYPE]) begin
            next_flags[irq_vec_pkg::SRC_EXT0] = (ext0_prev & ~ext0_pin_n)
                | (flags[irq_vec_pkg::SRC_EXT0] & ~sw_clear[irq_vec_pkg::SRC_EXT0]
                   & ~call_clear[irq_vec_pkg::SRC_EXT0]);
        end else begin
            next_flags[irq_vec_pkg::SRC_EXT0] = ~ext0_pin_n;
        end
        if (ctrl[irq_vec_pkg::CTRL_EXT1_TYPE]) begin
            next_flags[irq_vec_pkg::SRC_EXT1] = (ext1_prev & ~ext1_pin_n)
                | (flags[irq_vec_pkg::SRC_EXT1] & ~sw_clear[irq_vec_pkg::SRC_EXT1]
                   & ~call_clear[irq_vec_pkg::SRC_EXT1]);
        end else begin
            next_flags[irq_vec_pkg::SRC_EXT1] = ~ext1_pin_n;
        end
        // Set wins over a clear in the same cycle
        next_flags[irq_vec_pkg::SRC_TIMER0] = events.t0_overflow
            | (flags[irq_vec_pkg::SRC_TIMER0] & ~sw_clear[irq_vec_pkg::SRC_TIMER0]
               & ~call_clear[irq_vec_pkg::SRC_TIMER0]);
        next_flags[irq_vec_pkg::SRC_TIMER1] = events.t1_overflow
            | (flags[irq_vec_pkg::SRC_TIMER1] & ~sw_clear[irq_vec_pkg::SRC_TIMER1]
               & ~call_clear[irq_vec_pkg::SRC_TIMER1]);
        // Serial and timer 2 flags live in their peripherals; mirrored here
        next_flags[irq_vec_pkg::SRC_SERIAL] = events.serial_flag;
        next_flags[irq_vec_pkg::SRC_TIMER2] = events.timer2_flag;
        next_flags[irq_vec_pkg::SRC_SPI] = events.spi_done
            | (flags[irq_vec_pkg::SRC_SPI] & ~sw_clear[irq_vec_pkg::SRC_SPI]);
        next_flags[irq_vec_pkg::SRC_WDOG] = events.wdog_timeout
            | (flags[irq_vec_pkg::SRC_WDOG] & ~sw_clear[irq_vec_pkg::SRC_WDOG]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags     <= 8'h00;
            ext0_prev <= 1'b1;
            ext1_prev <= 1'b1;
        end else begin
            flags     <= next_flags;
            ext0_prev <= ext0_pin_n;
            ext1_prev <= ext1_pin_n;
        end
    end

    // Software registers and power-mode requests
    always_comb begin
        next_ctrl        = ctrl;
        next_enable      = enable;
        next_priority_hi = priority_hi;
        next_evt_mask    = evt_mask;
        if (wr_en) begin
            case (paddr)
                irq_vec_pkg::OFS_CTRL:     next_ctrl = pwdata[irq_vec_pkg::CTRL_W-1:0];
                irq_vec_pkg::OFS_ENABLE:   next_enable = pwdata[7:0];
                irq_vec_pkg::OFS_PRIORITY: next_priority_hi = pwdata[7:0];
                irq_vec_pkg::OFS_EVT_MASK: next_evt_mask = pwdata[irq_vec_pkg::EVT_W-1:0];
                default: next_enable = enable;
            endcase
        end
        // Both sleep bits drop on wake, so power-down never falls into idle
        if (take_wake) begin
            next_ctrl[irq_vec_pkg::CTRL_IDLE]  = 1'b0;
            next_ctrl[irq_vec_pkg::CTRL_PDOWN] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl        <= irq_vec_pkg::CTRL_RST;
            enable      <= irq_vec_pkg::ENA_RST;
            priority_hi <= irq_vec_pkg::PRI_RST;
            evt_mask    <= irq_vec_pkg::EVT_RST;
        end else begin
            ctrl        <= next_ctrl;
            enable      <= next_enable;
            priority_hi <= next_priority_hi;
            evt_mask    <= next_evt_mask;
        end
    end

    // Power mode and service levels
    always_comb begin
        next_mode = mode;
        case (mode)
            irq_vec_pkg::MODE_RUN: begin
                if (ctrl[irq_vec_pkg::CTRL_PDOWN]) begin
                    next_mode = irq_vec_pkg::MODE_PDOWN;
                end else if (ctrl[irq_vec_pkg::CTRL_IDLE]) begin
                    next_mode = irq_vec_pkg::MODE_IDLE;
                end
            end
            irq_vec_pkg::MODE_IDLE,
            irq_vec_pkg::MODE_PDOWN: begin
                if (take_wake) begin
                    next_mode = irq_vec_pkg::MODE_RUN;
                end
            end
            default: next_mode = irq_vec_pkg::MODE_RUN;
        endcase
        next_cpu_halted    = (next_mode != irq_vec_pkg::MODE_RUN);
        next_periph_halted = (next_mode == irq_vec_pkg::MODE_PDOWN);
        next_in_service = in_service;
        if (cpu.return_from_interrupt) begin
            if (in_service[1]) begin
                next_in_service[1] = 1'b0;
            end else begin
                next_in_service[0] = 1'b0;
            end
        end else if (take) begin
            next_in_service[sel_hi] = 1'b1;
        end
    end

    // Call: return address only, the status word is left to software
    always_comb begin
        next_call         = call;
        next_call.valid   = take;
        if (take) begin
            next_call.source  = sel_src;
            next_call.vector  = irq_vec_pkg::VEC_BASE
                              + 16'({13'h0000, sel_src} * irq_vec_pkg::VEC_STEP);
            next_call.push_pc = cpu.next_pc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode          <= irq_vec_pkg::MODE_RUN;
            in_service    <= 2'h0;
            cpu_halted    <= 1'b0;
            periph_halted <= 1'b0;
            call          <= '0;
        end else begin
            mode          <= next_mode;
            in_service    <= next_in_service;
            cpu_halted    <= next_cpu_halted;
            periph_halted <= next_periph_halted;
            call          <= next_call;
        end
    end

    // Event status, write one to clear, set wins
    always_comb begin
        next_evt_status = evt_status;
        if (wr_en && paddr == irq_vec_pkg::OFS_EVT_STAT) begin
            next_evt_status = evt_status & ~pwdata[irq_vec_pkg::EVT_W-1:0];
        end
        if (take) begin
            next_evt_status[irq_vec_pkg::EVT_CALL] = 1'b1;
        end
        if (take_wake) begin
            next_evt_status[irq_vec_pkg::EVT_WAKE] = 1'b1;
        end
        if (withheld) begin
            next_evt_status[irq_vec_pkg::EVT_WITHHELD] = 1'b1;
        end
        next_irq = |(next_evt_status & next_evt_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= irq_vec_pkg::EVT_RST;
            irq        <= 1'b0;
        end else begin
            evt_status <= next_evt_status;
            irq        <= next_irq;
        end
    end

endmodule
